// ---- design/adc_sel_pkg.sv ----
// Package: register map, field layout and routing types for input select
`default_nettype none
package adc_sel_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CH123_SEL = 8'h00;
  localparam logic [7:0] OFS_CH0_SEL = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_CMP1_CTRL = 8'h0c;
  localparam logic [7:0] OFS_CMP2_CTRL = 8'h10;
  localparam logic [7:0] OFS_CMP3_CTRL = 8'h14;
  localparam logic [7:0] OFS_ROUTE_A = 8'h18;
  localparam logic [7:0] OFS_ROUTE_B = 8'h1c;
  // Field positions
  localparam int POS_SA = 0;
  localparam int POS_NA = 1;
  localparam int POS_SB = 8;
  localparam int POS_NB = 9;
  localparam int POS_TWELVE = 0;
  localparam int POS_AMP_EN = 10;
  // Implemented-bit masks
  localparam logic [15:0] MASK_CH123 = 16'h0707;
  localparam logic [15:0] MASK_CH0 = 16'h9f9f;
  localparam logic [15:0] MASK_MODE = 16'h0001;
  localparam logic [15:0] MASK_CMP = 16'h0400;
  // Values after reset
  localparam logic [15:0] RST_CH123 = 16'h0000;
  localparam logic [15:0] RST_CH0 = 16'h0000;
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_CMP = 16'h0000;
  // Analog source codes for the multiplexer
  typedef enum logic [4:0] {
    SRC_AN0 = 5'h00, SRC_AN1 = 5'h01, SRC_AN2 = 5'h02, SRC_AN3 = 5'h03,
    SRC_AN6 = 5'h06, SRC_AN7 = 5'h07, SRC_AN8 = 5'h08, SRC_AN9 = 5'h09,
    SRC_AN10 = 5'h0a, SRC_AN11 = 5'h0b,
    SRC_AMP1 = 5'h10, SRC_AMP2 = 5'h11, SRC_AMP3 = 5'h12,
    SRC_VREFL = 5'h1f
  } src_t;
  // One channel's pair of selections
  typedef struct packed {
    src_t pos;
    src_t neg;
  } chan_sel_t;
  // Channels 3..1 of one sample set, channel 1 in the low bits
  typedef chan_sel_t [2:0] set_route_t;
  // Routing of all-zero fields with every amplifier off, channel 3 first
  localparam set_route_t RST_ROUTE = {SRC_AN2, SRC_VREFL, SRC_AN1, SRC_VREFL,
                                      SRC_AN0, SRC_VREFL};
endpackage : adc_sel_pkg
`default_nettype wire

// ---- design/adc_chan_decode.sv ----
// Module: decodes one channel's select fields into multiplexer sources
`default_nettype none
module adc_chan_decode (
  input wire logic [1:0] chan_i, // Channel index 0..2 for channels 1..3
  input wire logic pos_sel_i, // Positive select bit
  input wire logic [1:0] neg_sel_i, // Negative select code
  input wire logic [2:0] amp_en_i, // Amplifier enables, amp 1 in bit 0
  output adc_sel_pkg::chan_sel_t sel_o // Decoded selection
);
  import adc_sel_pkg::*;

  // Swap a shared pin for its amplifier output when enabled
  function automatic src_t shared(input src_t s, input logic [2:0] en);
    src_t r;
    r = s;
    if (s == SRC_AN3 && en[0]) begin
      r = SRC_AMP1;
    end else if (s == SRC_AN0 && en[1]) begin
      r = SRC_AMP2;
    end else if (s == SRC_AN6 && en[2]) begin
      r = SRC_AMP3;
    end
    return r;
  endfunction : shared

  src_t pos_raw; // Pin chosen before amplifier substitution
  src_t neg_raw; // Pin chosen before amplifier substitution

  // Positive and negative pin tables
  always_comb begin
    unique case (chan_i)
      2'd0: begin
        pos_raw = pos_sel_i ? SRC_AN3 : SRC_AN0;
        neg_raw = neg_sel_i[0] ? SRC_AN9 : SRC_AN6;
      end
      2'd1: begin
        pos_raw = pos_sel_i ? SRC_AN0 : SRC_AN1;
        neg_raw = neg_sel_i[0] ? SRC_AN10 : SRC_AN7;
      end
      default: begin
        pos_raw = pos_sel_i ? SRC_AN6 : SRC_AN2;
        neg_raw = neg_sel_i[0] ? SRC_AN11 : SRC_AN8;
      end
    endcase
    // Codes 0x pick the low reference
    if (!neg_sel_i[1]) begin
      neg_raw = SRC_VREFL;
    end
  end

  // Final selection with amplifier substitution
  always_comb begin
    sel_o.pos = shared(pos_raw, amp_en_i);
    sel_o.neg = shared(neg_raw, amp_en_i);
  end
endmodule : adc_chan_decode
`default_nettype wire

// ---- design/adc_input_select.sv ----
// Module: APB register block and input routing for converter channels 1-3
//
// The register offsets and register access over APB were chosen for this implementation.
`default_nettype none
// Overview of operation
// - Twelve-bit mode hides and disables channel fields
// - Set B negative code selects 9-11/6-8/reference
// - Set B positive bit selects 3/0/6 or 0/1/2
// - Set A negative decodes same as set B
// - Set A positive bit selects 3/0/6 or 0/1/2
// - Enabled amplifier output replaces its shared pin
// - Unused select register bits read zero
module adc_input_select (
  input wire logic SYS_CLK_I, // System clock, 25 MHz
  input wire logic RST_I, // Synchronous reset, active high
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB enable
  input wire logic PWRITE_I, // APB direction, high for write
  input wire logic [7:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I, // APB write data
  input wire logic [3:0] PSTRB_I, // APB write byte strobes
  output logic [31:0] PRDATA_O, // APB read data
  output logic PREADY_O, // APB ready
  output logic PSLVERR_O, // APB error for unmapped address
  output logic TWELVE_BIT_MODE_O, // Converter twelve-bit mode flag
  output logic [2:0] AMP_EN_O, // Amplifier enables, amp 1 in bit 0
  output adc_sel_pkg::set_route_t ROUTE_A_O, // Sample set A routing
  output adc_sel_pkg::set_route_t ROUTE_B_O // Sample set B routing
);
  import adc_sel_pkg::*;

  // Bus timing: the first access cycle is a wait state
  // Read data is captured in that wait state
  // Ready then stands for one cycle, error with it
  // A write lands at the edge that ends the ready cycle
  // Routing flops follow the stored fields one edge later
  // So the analog side never sees a half-written register
  // Twelve-bit mode masks the fields, storage is kept
  // Leaving the mode restores the old selection at once
  // Comparator registers keep only the amplifier enable
  // The rest of them belongs to the comparator itself
  // Amplifier enables reroute live, without a select write
  // Channel 0 select is stored and read back only

  // Address match, used for read and write decode
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFS_CH123_SEL) || (a == OFS_CH0_SEL) || (a == OFS_MODE) ||
           (a == OFS_CMP1_CTRL) || (a == OFS_CMP2_CTRL) ||
           (a == OFS_CMP3_CTRL) || (a == OFS_ROUTE_A) || (a == OFS_ROUTE_B);
  endfunction : is_mapped

  // Byte-lane merge of a 16-bit register under a mask
  // Lanes 2 and 3 carry nothing, registers are 16 bits
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] st,
                                        input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r & msk;
  endfunction : merge

  // Register storage
  logic [15:0] ch123_ff; // Channel 1-3 select register
  logic [15:0] ch0_ff; // Channel 0 select register
  logic [15:0] mode_ff; // Mode register
  logic [15:0] cmp_ff [3]; // Comparator control registers

  // Bus response flops
  logic pready_ff; // Ready pulse
  logic pslverr_ff; // Error flag with ready
  logic [31:0] prdata_ff; // Read data

  // Output flops
  logic twelve_ff; // Mode flag output
  logic [2:0] amp_en_ff; // Amplifier enable output
  set_route_t route_a_ff; // Set A routing output
  set_route_t route_b_ff; // Set B routing output

  // Decoded next values
  set_route_t nxt_route_a; // Decoded set A routing
  set_route_t nxt_route_b; // Decoded set B routing
  logic [31:0] nxt_prdata; // Read mux result

  // Combinational helpers
  logic [15:0] ch123_eff; // Visible channel 1-3 fields
  logic [2:0] amp_en; // Live amplifier enables
  logic access; // Access phase in progress
  logic launch; // Wait state, answer goes out next edge
  logic wr_en; // Write completes this edge

  // Access phase and completion strobes
  always_comb begin
    access = PSEL_I && PENABLE_I;
    launch = access && !pready_ff; // First access cycle only
    wr_en = access && pready_ff && PWRITE_I && is_mapped(PADDR_I);
  end

  // Channel fields disappear in twelve-bit mode
  // Hidden fields decode as zero fields would
  always_comb begin
    if (mode_ff[POS_TWELVE]) begin
      ch123_eff = 16'h0000;
    end else begin
      ch123_eff = ch123_ff & MASK_CH123;
    end
  end

  // Amplifier enables from comparator control bit 10
  // Enable i belongs to amplifier i+1
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      amp_en[i] = cmp_ff[i][POS_AMP_EN];
    end
  end

  // Channel 1-3 select register storage
  // Writes in twelve-bit mode still land here
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ch123_ff <= RST_CH123;
    end else if (wr_en && PADDR_I == OFS_CH123_SEL) begin
      ch123_ff <= merge(ch123_ff, PWDATA_I, PSTRB_I, MASK_CH123);
    end
  end

  // Channel 0 select register storage
  // Its fields steer nothing inside this block
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ch0_ff <= RST_CH0;
    end else if (wr_en && PADDR_I == OFS_CH0_SEL) begin
      ch0_ff <= merge(ch0_ff, PWDATA_I, PSTRB_I, MASK_CH0);
    end
  end

  // Mode register storage
  // Only the twelve-bit flag is implemented
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      mode_ff <= RST_MODE;
    end else if (wr_en && PADDR_I == OFS_MODE) begin
      mode_ff <= merge(mode_ff, PWDATA_I, PSTRB_I, MASK_MODE);
    end
  end

  // Comparator control registers, only the amplifier enable kept
  // Each comparator control sits one word above the last
  generate
    for (genvar g = 0; g < 3; g++) begin : g_cmp
      localparam logic [7:0] OFS = OFS_CMP1_CTRL + 8'(4 * g);
      always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          cmp_ff[g] <= RST_CMP;
        end else if (wr_en && PADDR_I == OFS) begin
          cmp_ff[g] <= merge(cmp_ff[g], PWDATA_I, PSTRB_I, MASK_CMP);
        end
      end
    end
  endgenerate

  // Per-channel decoders for both sample sets
  // Both sets see the same masked fields and live enables
  // An enable change reroutes without a select write
  // Channel index picks the pin table inside the decoder
  generate
    for (genvar c = 0; c < 3; c++) begin : g_dec
      // Set A fields
      adc_chan_decode u_dec_a (
        .chan_i(2'(c)),
        .pos_sel_i(ch123_eff[POS_SA]),
        .neg_sel_i(ch123_eff[POS_NA +: 2]),
        .amp_en_i(amp_en),
        .sel_o(nxt_route_a[c])
      );
      // Set B fields
      adc_chan_decode u_dec_b (
        .chan_i(2'(c)),
        .pos_sel_i(ch123_eff[POS_SB]),
        .neg_sel_i(ch123_eff[POS_NB +: 2]),
        .amp_en_i(amp_en),
        .sel_o(nxt_route_b[c])
      );
    end
  endgenerate

  // Set A routing output, one edge behind the fields
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      route_a_ff <= RST_ROUTE;
    end else begin
      route_a_ff <= nxt_route_a;
    end
  end

  // Set B routing output, one edge behind the fields
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      route_b_ff <= RST_ROUTE;
    end else begin
      route_b_ff <= nxt_route_b;
    end
  end

  // Twelve-bit mode flag output
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      twelve_ff <= 1'b0;
    end else begin
      twelve_ff <= mode_ff[POS_TWELVE];
    end
  end

  // Amplifier enable output
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      amp_en_ff <= 3'h0;
    end else begin
      amp_en_ff <= amp_en;
    end
  end

  // Read data mux from the live address
  // Sampled into the read flop only in the wait state
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (PADDR_I)
      // Select and mode registers
      OFS_CH123_SEL: begin
        nxt_prdata = {16'h0000, ch123_eff};
      end
      OFS_CH0_SEL: begin
        nxt_prdata = {16'h0000, ch0_ff};
      end
      OFS_MODE: begin
        nxt_prdata = {16'h0000, mode_ff};
      end
      // Comparator controls, amplifier enable only
      OFS_CMP1_CTRL: begin
        nxt_prdata = {16'h0000, cmp_ff[0]};
      end
      OFS_CMP2_CTRL: begin
        nxt_prdata = {16'h0000, cmp_ff[1]};
      end
      OFS_CMP3_CTRL: begin
        nxt_prdata = {16'h0000, cmp_ff[2]};
      end
      // Routing read-back, same flops as the outputs
      OFS_ROUTE_A: begin
        nxt_prdata = {2'b00, route_a_ff};
      end
      OFS_ROUTE_B: begin
        nxt_prdata = {2'b00, route_b_ff};
      end
      default: begin
        nxt_prdata = 32'h0000_0000; // Unmapped reads zero
      end
    endcase
  end

  // Ready: one wait state, then high for one cycle
  // Its own value blocks a second pulse in the same transfer
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= launch; // Falls after the completing edge
    end
  end

  // Error flag rides with ready for unmapped addresses
  // The write strobe ignores such addresses as well
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= launch && !is_mapped(PADDR_I);
    end
  end

  // Read data captured in the wait state
  // Held until the next read so it stands with ready
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      prdata_ff <= 32'h0000_0000;
    end else if (launch && !PWRITE_I) begin
      prdata_ff <= nxt_prdata; // Captured for the ready cycle
    end
  end

  // Outputs straight from flops
  // No logic between a flop and its pin
  // Keeps the analog switches free of decode glitches
  assign PRDATA_O = prdata_ff;
  assign PREADY_O = pready_ff;
  assign PSLVERR_O = pslverr_ff;
  assign TWELVE_BIT_MODE_O = twelve_ff;
  assign AMP_EN_O = amp_en_ff;
  assign ROUTE_A_O = route_a_ff;
  assign ROUTE_B_O = route_b_ff;
endmodule : adc_input_select
`default_nettype wire

// ---- dv/adc_input_select_sva.sv ----
// Checker: bus and routing assertions for the input select block
`default_nettype none
module adc_input_select_sva (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic TWELVE_BIT_MODE_O,
  input wire logic [2:0] AMP_EN_O,
  input wire adc_sel_pkg::set_route_t ROUTE_A_O,
  input wire adc_sel_pkg::set_route_t ROUTE_B_O
);
  import adc_sel_pkg::*;
  // Completed full-word select write, and select read
  logic sel_wr;
  logic sel_rd;
  assign sel_wr = PREADY_O && PWRITE_I && PADDR_I == OFS_CH123_SEL && PSTRB_I == 4'hf
    && !TWELVE_BIT_MODE_O;
  assign sel_rd = PREADY_O && !PWRITE_I && PADDR_I == OFS_CH123_SEL;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
  chk_ready_wait: assert property (PSEL_I && !PENABLE_I |=> !PREADY_O ##1 PREADY_O)
    else $error("ready not after one wait");
  chk_err_read: assert property (PSLVERR_O |-> PREADY_O && (PWRITE_I || PRDATA_O == 32'h0))
    else $error("bad error response");
  chk_unused_zero: assert property (sel_rd |-> (PRDATA_O & 32'hfffff8f8) == 32'h0)
    else $error("unused bits not zero");
  chk_twelve_read: assert property (sel_rd && TWELVE_BIT_MODE_O |-> PRDATA_O == 32'h0)
    else $error("fields visible in twelve-bit mode");
  chk_twelve_route: assert property (TWELVE_BIT_MODE_O |-> ROUTE_A_O[0].neg == SRC_VREFL
    && ROUTE_B_O[2].neg == SRC_VREFL && ROUTE_A_O[1].pos == SRC_AN1) else $error("twelve route");
  chk_neg_b: assert property (sel_wr && PWDATA_I[10:9] == 2'b11 |=> ##1
    ROUTE_B_O[1].neg == SRC_AN10) else $error("set B negative decode");
  chk_pos_b: assert property (sel_wr && PWDATA_I[8] |=> ##1
    ROUTE_B_O[2].pos == (AMP_EN_O[2] ? SRC_AMP3 : SRC_AN6)) else $error("set B positive decode");
  chk_neg_a: assert property (sel_wr && PWDATA_I[2:1] == 2'b10 |=> ##1
    ROUTE_A_O[2].neg == SRC_AN8) else $error("set A negative decode");
  chk_pos_a: assert property (sel_wr && !PWDATA_I[0] |=> ##1
    ROUTE_A_O[2].pos == SRC_AN2) else $error("set A positive decode");
  chk_amp_follow: assert property (PREADY_O && PWRITE_I && PADDR_I == OFS_CMP3_CTRL
    && PSTRB_I[1] |=> ##1 AMP_EN_O[2] == $past(PWDATA_I[10], 2))
    else $error("amplifier enable");
  // Main scenarios reached
  cover property (sel_wr);
  cover property (PSLVERR_O);
  cover property (sel_rd && TWELVE_BIT_MODE_O);
endmodule : adc_input_select_sva
`default_nettype wire

// ---- dv/tb.sv ----
// Testbench: register and routing scenarios for the input select block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_sel_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, twelve, erv;
  logic [2:0] amp;
  logic [31:0] rdv;
  set_route_t route_a, route_b;
  int fails = 0;
  int checks = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  adc_input_select dut (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TWELVE_BIT_MODE_O(twelve), .AMP_EN_O(amp),
    .ROUTE_A_O(route_a), .ROUTE_B_O(route_b));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rdv, exp);
  endtask : rd
  // Expected routing of one sample set
  function automatic set_route_t exp_route(input logic p, input logic [1:0] n,
                                           input logic [2:0] a);
    set_route_t r;
    r[0].pos = p ? (a[0] ? SRC_AMP1 : SRC_AN3) : (a[1] ? SRC_AMP2 : SRC_AN0);
    r[1].pos = p ? (a[1] ? SRC_AMP2 : SRC_AN0) : SRC_AN1;
    r[2].pos = p ? (a[2] ? SRC_AMP3 : SRC_AN6) : SRC_AN2;
    r[0].neg = !n[1] ? SRC_VREFL : n[0] ? SRC_AN9 : (a[2] ? SRC_AMP3 : SRC_AN6);
    r[1].neg = !n[1] ? SRC_VREFL : n[0] ? SRC_AN10 : SRC_AN7;
    r[2].neg = !n[1] ? SRC_VREFL : n[0] ? SRC_AN11 : SRC_AN8;
    return r;
  endfunction : exp_route
  // Route outputs once settled
  task automatic routes(input logic [15:0] v, input logic [2:0] a);
    @(negedge clk);
    chk({2'b0, route_a}, {2'b0, exp_route(v[0], v[2:1], a)});
    chk({2'b0, route_b}, {2'b0, exp_route(v[8], v[10:9], a)});
    @(posedge clk);
  endtask : routes
  task automatic t_reset;
    rd(OFS_CH123_SEL, 32'h0);
    routes(16'h0, 3'h0);
    rd(OFS_ROUTE_A, {2'b00, exp_route(1'b0, 2'b00, 3'h0)});
    rd(OFS_ROUTE_B, {2'b00, exp_route(1'b0, 2'b00, 3'h0)});
  endtask : t_reset
  task automatic t_store;
    wr(OFS_CH123_SEL, 32'hffffffff);
    rd(OFS_CH123_SEL, 32'h0707);
    apb(1'b1, OFS_CH123_SEL, 32'h0, 4'h1);
    rd(OFS_CH123_SEL, 32'h0700);
    wr(OFS_CH0_SEL, 32'hffffffff);
    rd(OFS_CH0_SEL, 32'h9f9f);
  endtask : t_store
  // Every code of both sets under every amplifier mix
  task automatic t_decode;
    logic [15:0] v;
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CMP1_CTRL, {21'h0, k[0], 10'h0});
      wr(OFS_CMP2_CTRL, {21'h0, k[1], 10'h0});
      wr(OFS_CMP3_CTRL, {21'h0, k[2], 10'h0});
      @(negedge clk);
      chk({29'h0, amp}, {29'h0, k[2:0]});
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        v = {5'h0, ~i[2:0], 5'h0, i[2:0]};
        wr(OFS_CH123_SEL, {16'h0, v});
        routes(v, k[2:0]);
      end
    end
  endtask : t_decode
  // Fields hidden in twelve-bit mode, kept for later
  task automatic t_twelve;
    wr(OFS_CH123_SEL, 32'h0707);
    wr(OFS_MODE, 32'h1);
    rd(OFS_CH123_SEL, 32'h0);
    chk({31'h0, twelve}, 32'h1);
    routes(16'h0, 3'h7);
    wr(OFS_CH123_SEL, 32'h0602);
    wr(OFS_MODE, 32'h0);
    rd(OFS_CH123_SEL, 32'h0602);
    chk({31'h0, twelve}, 32'h0);
    routes(16'h0602, 3'h7);
  endtask : t_twelve
  // Unmapped address refused
  task automatic t_unmapped;
    wr(8'h20, 32'hffffffff);
    chk({31'h0, erv}, 32'h1);
    rd(8'h20, 32'h0);
    chk({31'h0, erv}, 32'h1);
    rd(OFS_CH123_SEL, 32'h0602);
  endtask : t_unmapped
  // Verdict and end of run
  task automatic complete_run;
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    routes(16'h0, 3'h0);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_store();
    t_decode();
    t_twelve();
    t_unmapped();
    complete_run();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule : tb
bind adc_input_select adc_input_select_sva sva (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .TWELVE_BIT_MODE_O(TWELVE_BIT_MODE_O), .AMP_EN_O(AMP_EN_O),
  .ROUTE_A_O(ROUTE_A_O), .ROUTE_B_O(ROUTE_B_O));
`default_nettype wire
